// ### hdl/bdbg_core.sv
// Purpose: background debug status, clock select, security and command gating
// Assumes: serial bit engine and firmware live outside; ticks are enables
// Notes: registers reached by the internal debug register port only
module bdbg_core
  import bdbg_pkg::*;
#(
  parameter int SETTLE_N = SETTLE_TICKS,
  parameter int ACK_N = ACK_TICKS
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // chip mode and straps
  input wire logic SPECIAL_SC_IN,
  input wire logic FLASH_SECURED_IN,
  input wire logic PLL_CLOCK_SELECT_IN,
  // serial rate ticks
  input wire logic BUS_TICK_IN,
  input wire logic ALT_TICK_IN,
  // debug register port
  input wire bdbg_reg_req_t REG_REQ_IN,
  output logic [7:0] REG_RDATA_OUT,
  // processor side
  input wire logic [7:0] CCR_IN,
  input wire logic [15:0] REG_BASE_IN,
  input wire logic ACTIVATE_REQ_IN,
  output logic [7:0] CCR_RESTORE_OUT,
  // command decode from serial engine
  input wire logic CMD_START_IN,
  input wire logic CMD_HW_IN,
  input wire logic CMD_BGND_IN,
  input wire bdbg_fop_t CMD_FOP_IN,
  input wire logic DATA_DONE_IN,
  input wire logic ACK_ENABLE_IN,
  output logic HW_GO_OUT,
  output logic FW_GO_OUT,
  output bdbg_fop_t FW_OP_OUT,
  output logic CMD_REFUSED_OUT,
  output logic ACK_PULSE_OUT,
  // clock selection status
  output bdbg_clk_t SER_CLK_SEL_OUT,
  output bdbg_clk_t NEW_CLK_SEL_OUT,
  output logic CLK_SETTLED_OUT,
  // security and map status
  output logic DEBUG_ACTIVE_OUT,
  output logic SECURE_TABLE_MAP_OUT,
  output logic STD_TABLE_MAP_OUT,
  output logic SECURED_OUT,
  output logic FLASH_SEC_WR_OK_OUT,
  output logic SEC_FW_RAN_OUT
);
  typedef enum logic [3:0] {
    SS_BOOT = 4'b0001,
    SS_CHECK = 4'b0010,
    SS_HW_ONLY = 4'b0100,
    SS_OPEN = 4'b1000
  } bdbg_sec_t;

  bdbg_sec_t sec_q;
  bdbg_status_t sts_q;
  bdbg_clk_t ser_sel_q;
  bdbg_clk_t cur_sel;
  logic [7:0] ccr_hold_q;
  logic [7:0] rdata_q;
  logic secured_q;
  logic sec_ran_q;
  logic hw_go_q;
  logic fw_go_q;
  logic refused_q;
  bdbg_fop_t fop_q;
  logic settle_busy;
  logic settle_done;
  logic settled_q;
  logic ack_busy;
  logic ack_done;
  logic ser_tick;
  logic new_tick;
  logic wr_status;
  logic wr_ccr;
  logic rd_hit;
  logic fw_ok;
  logic bgnd_ok;
  logic activate;
  logic fw_exit;
  logic sw_change;
  logic new_sw;

  function automatic logic pick_tick(input bdbg_clk_t s, input logic bt, input logic at);
    pick_tick = (s == CKS_ALT) ? at : bt;
  endfunction : pick_tick

  always_comb begin
    if (!PLL_CLOCK_SELECT_IN) begin
      cur_sel = CKS_BUS;
    end else if (!sts_q.clk_switch) begin
      cur_sel = CKS_ALT;
    end else begin
      cur_sel = CKS_PLL;
    end
  end

  assign wr_status = REG_REQ_IN.sel && REG_REQ_IN.wr && (REG_REQ_IN.addr == OFS_STATUS);
  assign wr_ccr = REG_REQ_IN.sel && REG_REQ_IN.wr && (REG_REQ_IN.addr == OFS_CCR_HOLD);
  assign rd_hit = REG_REQ_IN.sel && !REG_REQ_IN.wr;

  assign new_sw = REG_REQ_IN.wdata[BIT_CLK_SWITCH];
  assign sw_change = wr_status && (REG_REQ_IN.src == SRC_HWCMD) && (new_sw != sts_q.clk_switch);

  // firmware commands need active mode and SS_OPEN, also reached secured outside special single-chip
  assign fw_ok = sts_q.active && (sec_q == SS_OPEN);
  assign bgnd_ok = sts_q.enable && (sec_q != SS_CHECK);
  assign activate = !sts_q.active && sts_q.enable
    && (ACTIVATE_REQ_IN || (CMD_START_IN && CMD_HW_IN && CMD_BGND_IN && bgnd_ok));
  assign fw_exit = CMD_START_IN && !CMD_HW_IN && fw_ok && (CMD_FOP_IN == FOP_EXIT);

  // security sequencing, strap caught after reset release
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sec_q <= SS_BOOT;
      secured_q <= 1'b0;
      sec_ran_q <= 1'b0;
    end else begin
      unique case (sec_q)
        SS_BOOT: begin
          secured_q <= FLASH_SECURED_IN;
          if (FLASH_SECURED_IN && SPECIAL_SC_IN) begin
            sec_q <= SS_CHECK;
          end else begin
            sec_q <= SS_OPEN;
          end
        end
        SS_CHECK: begin
          if (wr_status && REG_REQ_IN.src == SRC_SECFW && REG_REQ_IN.wdata[BIT_UNSECURE]) begin
            sec_q <= SS_OPEN;
            sec_ran_q <= 1'b1;
          end else if (wr_status && REG_REQ_IN.src == SRC_SECFW
                       && REG_REQ_IN.wdata[BIT_ENABLE]) begin
            sec_q <= SS_HW_ONLY;
            sec_ran_q <= 1'b1;
          end
        end
        SS_HW_ONLY: begin
          sec_q <= SS_HW_ONLY;
        end
        SS_OPEN: begin
          sec_q <= SS_OPEN;
        end
        default: begin
          sec_q <= SS_BOOT;
        end
      endcase
    end
  end

  // status: enable bit
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sts_q.enable <= RST_STATUS[BIT_ENABLE];
    end else if (wr_status && REG_REQ_IN.src != SRC_USER) begin
      // secure firmware may enable without unsecure
      sts_q.enable <= REG_REQ_IN.wdata[BIT_ENABLE];
    end
  end

  // status: active bit, set by hardware only, cleared on exit
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sts_q.active <= RST_STATUS[BIT_ACTIVE];
    end else if (activate) begin
      sts_q.active <= 1'b1;
    end else if (fw_exit) begin
      sts_q.active <= 1'b0;
    end else if (wr_status && REG_REQ_IN.src == SRC_FW && !REG_REQ_IN.wdata[BIT_ACTIVE]) begin
      sts_q.active <= 1'b0;
    end
  end

  // status: clock switch
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sts_q.clk_switch <= RST_STATUS[BIT_CLK_SWITCH];
    end else if (sw_change) begin
      sts_q.clk_switch <= new_sw;
    end
  end

  // status: unsecure
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sts_q.unsecure <= 1'b0;
    // secure firmware in special single-chip only
    end else if (wr_status && REG_REQ_IN.src == SRC_SECFW && SPECIAL_SC_IN) begin
      sts_q.unsecure <= REG_REQ_IN.wdata[BIT_UNSECURE];
    end
  end

  // unimplemented status bits stay zero
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sts_q.rsvd <= '0;
      sts_q.zero <= 1'b0;
    end else begin
      sts_q.rsvd <= '0;
      sts_q.zero <= 1'b0;
    end
  end

  // condition code holding register
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ccr_hold_q <= SPECIAL_SC_IN ? RST_CCR_SPECIAL : RST_CCR_NORMAL;
    end else if (activate) begin
      ccr_hold_q <= CCR_IN;
    end else if (wr_ccr) begin
      ccr_hold_q <= REG_REQ_IN.wdata;
    end
  end

  // register reads; user programs see nothing of this window
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 8'h00;
    end else if (rd_hit && REG_REQ_IN.src != SRC_USER) begin
      unique case (REG_REQ_IN.addr)
        OFS_STATUS: rdata_q <= sts_q;
        OFS_CCR_HOLD: rdata_q <= ccr_hold_q;
        OFS_REG_POS: rdata_q <= {1'b0, REG_BASE_IN[BASE_MSB:BASE_LSB], 3'h0};
        default: rdata_q <= 8'h00;
      endcase
    end else if (rd_hit) begin
      rdata_q <= 8'h00;
    end
  end

  // serial timing switches at the next command start
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ser_sel_q <= CKS_BUS;
    end else if (CMD_START_IN) begin
      ser_sel_q <= cur_sel;
    end
  end

  // settle counted on the clock of the data portion
  assign ser_tick = pick_tick(ser_sel_q, BUS_TICK_IN, ALT_TICK_IN);
  // acknowledge runs at the newly selected rate
  assign new_tick = pick_tick(cur_sel, BUS_TICK_IN, ALT_TICK_IN);

  bdbg_tick_cnt #(
    .W(TICK_CNT_W),
    .N(SETTLE_N)
  ) u_settle (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .start_in(sw_change),
    .tick_in(ser_tick),
    .busy_out(settle_busy),
    .done_out(settle_done)
  );

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      settled_q <= 1'b1;
    end else if (sw_change) begin
      settled_q <= 1'b0;
    end else if (settle_done) begin
      settled_q <= 1'b1;
    end
  end

  // pulse after a command completes with handshake on
  bdbg_tick_cnt #(
    .W(TICK_CNT_W),
    .N(ACK_N)
  ) u_ack (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .start_in(DATA_DONE_IN && ACK_ENABLE_IN),
    .tick_in(new_tick),
    .busy_out(ack_busy),
    .done_out(ack_done)
  );

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      hw_go_q <= 1'b0;
      fw_go_q <= 1'b0;
      refused_q <= 1'b0;
      fop_q <= FOP_NONE;
    end else begin
      hw_go_q <= 1'b0;
      fw_go_q <= 1'b0;
      refused_q <= 1'b0;
      if (CMD_START_IN && CMD_HW_IN) begin
        // background request ignored while disabled
        if (CMD_BGND_IN && !bgnd_ok) begin
          refused_q <= 1'b1;
        end else begin
          hw_go_q <= 1'b1;
        end
      end else if (CMD_START_IN) begin
        if (fw_ok) begin
          fw_go_q <= 1'b1;
          fop_q <= CMD_FOP_IN;
        end else begin
          refused_q <= 1'b1;
        end
      end
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign CCR_RESTORE_OUT = ccr_hold_q;
  assign HW_GO_OUT = hw_go_q;
  assign FW_GO_OUT = fw_go_q;
  assign FW_OP_OUT = fop_q;
  assign CMD_REFUSED_OUT = refused_q;
  assign ACK_PULSE_OUT = ack_busy;
  assign SER_CLK_SEL_OUT = ser_sel_q;
  assign NEW_CLK_SEL_OUT = cur_sel;
  assign CLK_SETTLED_OUT = settled_q;
  assign DEBUG_ACTIVE_OUT = sts_q.active;
  // secure table mapped while check runs
  assign SECURE_TABLE_MAP_OUT = (sec_q == SS_CHECK);
  assign STD_TABLE_MAP_OUT = sts_q.active || (sec_q == SS_CHECK);
  assign SECURED_OUT = secured_q && !sts_q.unsecure;
  // flash security bits changeable only in SS_OPEN, also reached secured outside special single-chip
  assign FLASH_SEC_WR_OK_OUT = (sec_q == SS_OPEN);
  // tells the mapping block its reset values are gone
  assign SEC_FW_RAN_OUT = sec_ran_q;
endmodule : bdbg_core

// ### hdl/bdbg_tick_cnt.sv
// Purpose: counts a fixed number of rate ticks after a start pulse
// Assumes: tick is a one-cycle enable at the rate being measured
// Notes: a start while busy restarts the count
module bdbg_tick_cnt #(
  parameter int W = 8,
  parameter int N = 150
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic tick_in,
  output logic busy_out,
  output logic done_out
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_in) begin
        cnt_q <= '0;
        busy_q <= 1'b1;
      end else if (busy_q && tick_in) begin
        if (cnt_q == W'(N - 1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
endmodule : bdbg_tick_cnt

// ### shared/bdbg_pkg.sv
// Purpose: constants and types shared by the background debug state block
// Assumes: one 20 MHz clock, synchronous active-low reset
// Notes: serial-rate ticks arrive as one-cycle enables from outside dividers
// Overview of operation
// - clock switch bit changes only through a hardware debug command write.
// - new debug clock is settled after 150 ticks of the clock in use.
// - serial timing takes the new clock from the next command start.
// - pll select 0 gives bus clock; 1 with switch 0 alternate; both 1 pll bus.
// - with handshake on, acknowledge pulse is timed at the newly selected rate.
// - unsecure bit written only by secure firmware in special single-chip; resets zero.
// - secure entry keeps unsecure zero and maps the secure firmware table.
// - erase check passes: unsecure set, secure table off, all commands allowed.
// - erase check fails: enable set, unsecure clear; hardware commands only.
// - unsecured flash security bits writable; secured again at next reset.
// - activation copies condition codes to holding register; writes alter restored value.
// - special single-chip reset loads holding register with D8, not D0.
// - position register is read-only; bits 6:3 mirror base bits 14:11.
// - host commands split into hardware and firmware commands.
// - hardware commands other than background run any time; firmware commands only while active.
// - firmware commands access D, X, Y, SP, PC and exit active mode.
// - after secure firmware runs, eeprom position and page leave reset values.
// - status bit 7 enables activation and background; other hardware commands run regardless.
package bdbg_pkg;
  localparam logic [15:0] OFS_STATUS = 16'hFF01;
  localparam logic [15:0] OFS_CCR_HOLD = 16'hFF06;
  localparam logic [15:0] OFS_REG_POS = 16'hFF07;
  localparam logic [15:0] OFS_WIN_BASE = 16'hFF00;
  localparam logic [15:0] OFS_WIN_LAST = 16'hFF07;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_CLK_SWITCH = 2;
  localparam int BIT_UNSECURE = 1;
  localparam int POS_LSB = 3;
  localparam int POS_MSB = 6;
  localparam int BASE_LSB = 11;
  localparam int BASE_MSB = 14;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CCR_SPECIAL = 8'hD8;
  localparam logic [7:0] RST_CCR_NORMAL = 8'hD0;
  localparam int SETTLE_TICKS = 150;
  localparam int ACK_TICKS = 16;
  localparam int TICK_CNT_W = 8;

  typedef enum logic [1:0] {
    SRC_USER = 2'h0,
    SRC_HWCMD = 2'h1,
    SRC_FW = 2'h2,
    SRC_SECFW = 2'h3
  } bdbg_src_t;

  typedef enum logic [1:0] {
    CKS_BUS = 2'h0,
    CKS_ALT = 2'h1,
    CKS_PLL = 2'h2
  } bdbg_clk_t;

  typedef enum logic [3:0] {
    FOP_NONE = 4'h0,
    FOP_RD_D = 4'h1,
    FOP_RD_X = 4'h2,
    FOP_RD_Y = 4'h3,
    FOP_RD_SP = 4'h4,
    FOP_RD_PC = 4'h5,
    FOP_WR_D = 4'h6,
    FOP_WR_X = 4'h7,
    FOP_WR_Y = 4'h8,
    FOP_WR_SP = 4'h9,
    FOP_WR_PC = 4'hA,
    FOP_EXIT = 4'hB
  } bdbg_fop_t;

  typedef struct packed {
    logic sel;
    logic wr;
    bdbg_src_t src;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bdbg_reg_req_t;

  typedef struct packed {
    logic enable;
    logic active;
    logic [2:0] rsvd;
    logic clk_switch;
    logic unsecure;
    logic zero;
  } bdbg_status_t;
endpackage : bdbg_pkg

// ### test/bdbg_core_asserts.sv
// Purpose: port-level checks on the background debug core
// Assumes: one clock, synchronous active-low reset
// Notes: the switch bit is internal, so clock checks lean on select outputs
module bdbg_core_asserts
  import bdbg_pkg::*;
#(
  parameter int SETTLE_N = SETTLE_TICKS,
  parameter int ACK_N = ACK_TICKS
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PLL_CLOCK_SELECT_IN,
  input wire logic BUS_TICK_IN,
  input wire logic ALT_TICK_IN,
  input wire bdbg_reg_req_t REG_REQ_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic [7:0] CCR_IN,
  input wire logic [15:0] REG_BASE_IN,
  input wire logic [7:0] CCR_RESTORE_OUT,
  input wire logic CMD_START_IN,
  input wire logic CMD_HW_IN,
  input wire logic CMD_BGND_IN,
  input wire bdbg_fop_t CMD_FOP_IN,
  input wire logic DATA_DONE_IN,
  input wire logic ACK_ENABLE_IN,
  input wire logic HW_GO_OUT,
  input wire logic FW_GO_OUT,
  input wire bdbg_fop_t FW_OP_OUT,
  input wire logic CMD_REFUSED_OUT,
  input wire logic ACK_PULSE_OUT,
  input wire bdbg_clk_t SER_CLK_SEL_OUT,
  input wire bdbg_clk_t NEW_CLK_SEL_OUT,
  input wire logic CLK_SETTLED_OUT,
  input wire logic DEBUG_ACTIVE_OUT,
  input wire logic SECURED_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  logic [15:0] settle_q;
  logic rate_tick;
  logic hw_st_wr;
  logic [3:0] base_pos;
  assign rate_tick = (SER_CLK_SEL_OUT == CKS_ALT) ? ALT_TICK_IN : BUS_TICK_IN;
  assign hw_st_wr = REG_REQ_IN.sel && REG_REQ_IN.wr && REG_REQ_IN.src == SRC_HWCMD &&
    REG_REQ_IN.addr == OFS_STATUS;
  assign base_pos = REG_BASE_IN[14:11];

  // ticks seen while settling; a tick on the write edge itself may be missed
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || CLK_SETTLED_OUT) begin
      settle_q <= 16'h0000;
    end else if (rate_tick) begin
      settle_q <= settle_q + 16'h0001;
    end
  end

  sequence fw_cmd_s;
    CMD_START_IN && !CMD_HW_IN;
  endsequence
  sequence pos_read_s;
    REG_REQ_IN.sel && !REG_REQ_IN.wr && REG_REQ_IN.src != SRC_USER &&
      REG_REQ_IN.addr == OFS_REG_POS;
  endsequence

  fw_gate_a: assert property (fw_cmd_s ##0 !DEBUG_ACTIVE_OUT |=> !FW_GO_OUT && CMD_REFUSED_OUT)
    else $error("firmware command ran while inactive");
  hw_go_a: assert property (CMD_START_IN && CMD_HW_IN && !CMD_BGND_IN |=> HW_GO_OUT)
    else $error("hardware command not started");
  fw_exit_a: assert property (fw_cmd_s ##0 (CMD_FOP_IN == FOP_EXIT && DEBUG_ACTIVE_OUT &&
    !SECURED_OUT) |=> FW_GO_OUT && FW_OP_OUT == FOP_EXIT && !DEBUG_ACTIVE_OUT)
    else $error("exit command did not leave active mode");
  sw_guard_a: assert property (REG_REQ_IN.sel && REG_REQ_IN.wr && REG_REQ_IN.src != SRC_HWCMD
    ##1 $stable(PLL_CLOCK_SELECT_IN) |-> $stable(NEW_CLK_SEL_OUT))
    else $error("clock select moved on a non-hardware write");
  settle_drop_a: assert property ($fell(CLK_SETTLED_OUT) |-> $past(hw_st_wr))
    else $error("settling started without a hardware status write");
  settle_len_a: assert property ($rose(CLK_SETTLED_OUT) |->
    settle_q >= SETTLE_N - 1 && settle_q <= SETTLE_N + 1)
    else $error("settling span has the wrong tick count");
  ack_start_a: assert property (DATA_DONE_IN && ACK_ENABLE_IN |=> ACK_PULSE_OUT)
    else $error("acknowledge pulse missing");
  ccr_capture_a: assert property ($rose(DEBUG_ACTIVE_OUT) |->
    CCR_RESTORE_OUT == $past(CCR_IN))
    else $error("condition codes not captured on activation");
  pos_read_a: assert property (pos_read_s |=>
    REG_RDATA_OUT == {1'h0, $past(base_pos), 3'h0})
    else $error("position register read wrong");
endmodule : bdbg_core_asserts

bind bdbg_core bdbg_core_asserts #(.SETTLE_N(SETTLE_N), .ACK_N(ACK_N)) u_chk (.*);

// ### test/bdbg_host.sv
// Purpose: host-side model giving serial rate ticks and decoded command pulses
// Assumes: bus-rate tick every 3 cycles, alternate-rate tick every 5
// Notes: idle hw and background lines carry inverted values so stale levels never pass as valid
module bdbg_host
  import bdbg_pkg::*;
(
  // clock and status
  input wire logic clk_in,
  input wire logic settled_in,
  // rate ticks
  output logic bus_tick_out = 1'h0,
  output logic alt_tick_out = 1'h0,
  // command decode
  output logic cmd_start_out = 1'h0,
  output logic cmd_hw_out = 1'h0,
  output logic cmd_bgnd_out = 1'h0,
  output bdbg_fop_t cmd_fop_out = FOP_NONE,
  output logic data_done_out = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;

  always @(posedge clk_in) begin
    n <= n + 1;
    bus_tick_out <= (n % 3 == 0);
    alt_tick_out <= (n % 5 == 0);
  end

  task automatic send(input logic hw, input logic bg, input bdbg_fop_t op);
    int t;
    t = 0;
    while (settled_in !== 1'h1 && t < 2000) begin
      @(posedge clk_in);
      t++;
    end
    @(posedge clk_in);
    cmd_start_out <= 1'h1;
    cmd_hw_out <= hw;
    cmd_bgnd_out <= bg;
    cmd_fop_out <= op;
    @(posedge clk_in);
    cmd_start_out <= 1'h0;
    cmd_hw_out <= ~hw;
    cmd_bgnd_out <= ~bg;
  endtask : send

  task automatic done();
    @(posedge clk_in);
    data_done_out <= 1'h1;
    @(posedge clk_in);
    data_done_out <= 1'h0;
  endtask : done
endmodule : bdbg_host

// ### test/tb_background_debug_status_security.sv
// Purpose: self-checking bench for the background debug core
// Assumes: host model gives ticks and commands; counts shortened to 4
// Notes: expected values come from integer state kept beside the design
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_background_debug_status_security
  import bdbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NT = 4;
  logic CLK_IN = 1'h0;
  logic RST_N_IN = 1'h0;
  logic SPECIAL_SC_IN = 1'h1;
  logic FLASH_SECURED_IN = 1'h0;
  logic PLL_CLOCK_SELECT_IN = 1'h0;
  logic ACTIVATE_REQ_IN = 1'h0;
  logic ACK_ENABLE_IN = 1'h0;
  logic [7:0] CCR_IN = 8'h00;
  logic [15:0] REG_BASE_IN = 16'h0000;
  bdbg_reg_req_t REG_REQ_IN = '0;
  logic BUS_TICK_IN, ALT_TICK_IN, CMD_START_IN, CMD_HW_IN, CMD_BGND_IN, DATA_DONE_IN;
  bdbg_fop_t CMD_FOP_IN, FW_OP_OUT;
  bdbg_clk_t SER_CLK_SEL_OUT, NEW_CLK_SEL_OUT, ecs;
  logic [7:0] REG_RDATA_OUT, CCR_RESTORE_OUT, rd, v;
  logic HW_GO_OUT, FW_GO_OUT, CMD_REFUSED_OUT, ACK_PULSE_OUT, CLK_SETTLED_OUT;
  logic DEBUG_ACTIVE_OUT, SECURE_TABLE_MAP_OUT, STD_TABLE_MAP_OUT, SECURED_OUT;
  logic FLASH_SEC_WR_OK_OUT, SEC_FW_RAN_OUT;
  int err_count = 0;
  int num_checks = 0;
  int en, sw, act, un, n, k, per;

  always #25 CLK_IN = ~CLK_IN;

  bdbg_core #(.SETTLE_N(NT), .ACK_N(NT)) dut (.*);
  bdbg_host host (.clk_in(CLK_IN), .settled_in(CLK_SETTLED_OUT), .bus_tick_out(BUS_TICK_IN),
    .alt_tick_out(ALT_TICK_IN), .cmd_start_out(CMD_START_IN), .cmd_hw_out(CMD_HW_IN),
    .cmd_bgnd_out(CMD_BGND_IN), .cmd_fop_out(CMD_FOP_IN), .data_done_out(DATA_DONE_IN));

  function automatic logic [7:0] st_exp();
    st_exp = {en[0], act[0], 3'h0, sw[0], un[0], 1'h0};
  endfunction : st_exp

  task automatic rg(input logic w, input bdbg_src_t s, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge CLK_IN);
    REG_REQ_IN <= '{sel: 1'h1, wr: w, src: s, addr: a, wdata: d};
    @(posedge CLK_IN);
    REG_REQ_IN <= '{sel: 1'h0, wr: ~w, src: s, addr: ~a, wdata: ~d};
    #1;
    rd = REG_RDATA_OUT;
  endtask : rg

  task automatic cm(input logic hw, input logic bg, input bdbg_fop_t op);
    host.send(hw, bg, op);
    #1;
  endtask : cm

  task automatic act_pulse();
    @(posedge CLK_IN);
    ACTIVATE_REQ_IN <= 1'h1;
    @(posedge CLK_IN);
    ACTIVATE_REQ_IN <= 1'h0;
    #1;
  endtask : act_pulse

  task automatic do_reset(input logic sec);
    @(posedge CLK_IN);
    RST_N_IN <= 1'h0;
    FLASH_SECURED_IN <= sec;
    repeat (8) @(posedge CLK_IN);
    RST_N_IN <= 1'h1;
    repeat (2) @(posedge CLK_IN);
    #1;
    en = 0;
    sw = 0;
    act = 0;
    un = 0;
  endtask : do_reset

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge CLK_IN);
    err_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h395495D2));
    do_reset(1'h0);
    `CHK("ccr hold", 8'hD8, CCR_RESTORE_OUT)
    rg(1'h0, SRC_HWCMD, OFS_STATUS, 8'h00);
    `CHK("status", st_exp(), rd)
    for (n = 0; n < 4; n++) begin
      @(posedge CLK_IN);
      REG_BASE_IN <= 16'($urandom);
      rg(1'h1, SRC_HWCMD, OFS_REG_POS, 8'hFF);
      rg(1'h0, SRC_HWCMD, OFS_REG_POS, 8'h00);
      `CHK("position", {1'h0, REG_BASE_IN[14:11], 3'h0}, rd)
    end
    $display("test reset and position done");
    for (n = 0; n < 4; n++) begin
      @(posedge CLK_IN);
      PLL_CLOCK_SELECT_IN <= n[1];
      ACK_ENABLE_IN <= 1'h1;
      rg(1'h1, SRC_USER, OFS_STATUS, {5'h00, ~n[0], 2'h0});
      rg(1'h1, SRC_HWCMD, OFS_STATUS, {5'h00, n[0], 2'h0});
      sw = n[0];
      rg(1'h0, SRC_HWCMD, OFS_STATUS, 8'h00);
      `CHK("status", st_exp(), rd)
      `CHK("settled", n == 0, CLK_SETTLED_OUT)
      ecs = !n[1] ? CKS_BUS : (n[0] ? CKS_PLL : CKS_ALT);
      `CHK("new clk", ecs, NEW_CLK_SEL_OUT)
      cm(1'h1, 1'h0, FOP_NONE);
      `CHK("hw go", 1'h1, HW_GO_OUT)
      `CHK("ser clk", ecs, SER_CLK_SEL_OUT)
      host.done();
      #1;
      per = (ecs == CKS_ALT) ? 5 : 3;
      k = 0;
      while (ACK_PULSE_OUT === 1'h1 && k < 200) begin
        @(posedge CLK_IN);
        #1;
        k++;
      end
      `CHK("ack len", 1'h1, k >= (NT - 1) * per && k <= (NT + 1) * per)
    end
    $display("test clock switch done");
    @(posedge CLK_IN);
    PLL_CLOCK_SELECT_IN <= 1'h0;
    CCR_IN <= 8'($urandom);
    rg(1'h1, SRC_HWCMD, OFS_STATUS, 8'h00);
    sw = 0;
    act_pulse();
    `CHK("active", 1'h0, DEBUG_ACTIVE_OUT)
    cm(1'h0, 1'h0, FOP_RD_D);
    `CHK("refused", 1'h1, CMD_REFUSED_OUT)
    rg(1'h1, SRC_HWCMD, OFS_STATUS, 8'h80);
    en = 1;
    act_pulse();
    act = 1;
    `CHK("ccr hold", CCR_IN, CCR_RESTORE_OUT)
    v = 8'($urandom);
    rg(1'h1, SRC_USER, OFS_CCR_HOLD, v);
    `CHK("ccr write", v, CCR_RESTORE_OUT)
    rg(1'h0, SRC_HWCMD, OFS_STATUS, 8'h00);
    `CHK("status", st_exp(), rd)
    for (n = 1; n < 11; n++) begin
      cm(1'h0, 1'h0, bdbg_fop_t'(n));
      `CHK("fw go", 1'h1, FW_GO_OUT)
      `CHK("fw op", bdbg_fop_t'(n), FW_OP_OUT)
    end
    cm(1'h0, 1'h0, FOP_EXIT);
    `CHK("active", 1'h0, DEBUG_ACTIVE_OUT)
    cm(1'h1, 1'h1, FOP_NONE);
    `CHK("active", 1'h1, DEBUG_ACTIVE_OUT)
    cm(1'h0, 1'h0, FOP_EXIT);
    rg(1'h1, SRC_HWCMD, OFS_STATUS, 8'h00);
    cm(1'h1, 1'h1, FOP_NONE);
    `CHK("refused", 1'h1, CMD_REFUSED_OUT)
    $display("test activation done");
    do_reset(1'h1);
    `CHK("secure map", 1'h1, SECURE_TABLE_MAP_OUT)
    `CHK("std map", 1'h1, STD_TABLE_MAP_OUT)
    rg(1'h1, SRC_USER, OFS_STATUS, 8'h02);
    `CHK("secured", 1'h1, SECURED_OUT)
    rg(1'h1, SRC_SECFW, OFS_STATUS, 8'h02);
    `CHK("secured", 1'h0, SECURED_OUT)
    `CHK("secure map", 1'h0, SECURE_TABLE_MAP_OUT)
    `CHK("flash wr", 1'h1, FLASH_SEC_WR_OK_OUT)
    un = 1;
    rg(1'h0, SRC_HWCMD, OFS_STATUS, 8'h00);
    `CHK("status", st_exp(), rd)
    do_reset(1'h1);
    `CHK("secured", 1'h1, SECURED_OUT)
    rg(1'h1, SRC_SECFW, OFS_STATUS, 8'h80);
    en = 1;
    `CHK("fw ran", 1'h1, SEC_FW_RAN_OUT)
    rg(1'h0, SRC_HWCMD, OFS_STATUS, 8'h00);
    `CHK("status", st_exp(), rd)
    cm(1'h1, 1'h1, FOP_NONE);
    `CHK("hw go", 1'h1, HW_GO_OUT)
    `CHK("active", 1'h1, DEBUG_ACTIVE_OUT)
    cm(1'h0, 1'h0, FOP_RD_PC);
    `CHK("refused", 1'h1, CMD_REFUSED_OUT)
    @(posedge CLK_IN);
    SPECIAL_SC_IN <= 1'h0;
    do_reset(1'h1);
    `CHK("ccr hold", 8'hD0, CCR_RESTORE_OUT)
    rg(1'h1, SRC_SECFW, OFS_STATUS, 8'h02);
    `CHK("secured", 1'h1, SECURED_OUT)
    $display("test security done");
    complete_run();
  end
endmodule : tb_background_debug_status_security
